// ===== rsqc_pkg.sv
// Purpose: constants shared by the reset sequencer and its delay timer
// Assumes: 10 MHz reference clock, 32-bit AXI4-Lite register bus
// Notes:   all delays are nominal figures turned into reference cycles
package rsqc_pkg;
  // ------------------------------------------------------------
  // clock and delays
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 100;
  localparam int POR_DELAY_NS     = 10000;    // power-on delay
  localparam int STARTUP_REG_NS   = 20000;    // start-up delay, regulator on
  localparam int PWRUP_TIMER_MS   = 64;       // power-up timer, regulator off
  localparam int RST_TIME_NS      = 20000;    // internal state reset time
  localparam int PLL_LOCK_NS      = 20000;    // pll lock time
  localparam int MON_DELAY_NS     = 100000;   // monitor start delay
  localparam int TMR_W            = 20;
  localparam logic [TMR_W-1:0] POR_CYC     = TMR_W'((POR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] STARTUP_CYC = TMR_W'((STARTUP_REG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] PWRUP_CYC   = TMR_W'((PWRUP_TIMER_MS * 1000000) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] RST_CYC     = TMR_W'((RST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] LOCK_CYC    = TMR_W'((PLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] MON_CYC     = TMR_W'((MON_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [9:0]       OST_LAST    = 10'h3ff;  // 1024 oscillator periods
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0]  ADDR_FLAGS   = 8'h00;
  localparam logic [7:0]  ADDR_OSC     = 8'h04;
  localparam logic [7:0]  ADDR_STATUS  = 8'h08;
  localparam logic [15:0] FLAGS_RESET  = 16'h0003;
  localparam logic [15:0] FLAGS_MASK   = 16'hc1ff;
  localparam int BIT_POR   = 0;
  localparam int BIT_BOR   = 1;
  localparam int BIT_IDLE  = 2;
  localparam int BIT_SLEEP = 3;
  localparam int BIT_DOGTO = 4;
  localparam int BIT_SDOG  = 5;
  localparam int BIT_SOFT  = 6;
  localparam int BIT_PIN   = 7;
  localparam int BIT_BADOP = 14;
  localparam int BIT_TRAP  = 15;
  localparam int OSC_LSB   = 12;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ------------------------------------------------------------
  // clock sources and sequence states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    OSC_FRC = 3'h0, OSC_FRCPLL = 3'h1, OSC_XT = 3'h2, OSC_XTPLL = 3'h3,
    OSC_SOSC = 3'h4, OSC_INTERNAL_SLOW_RC = 3'h5, OSC_EC = 3'h6, OSC_ECPLL = 3'h7
  } rsqc_osc_t;
  typedef enum logic [2:0] {
    ST_HOLD = 3'h0, ST_POR = 3'h1, ST_START = 3'h2, ST_RST = 3'h3,
    ST_RUN = 3'h4, ST_WAKE = 3'h5
  } rsqc_state_t;
endpackage

// ===== rsqc_tmr_if.sv
// Purpose: carrier between the sequencer and one delay timer
// Assumes: single clock domain
// Notes:   load is sampled only while start is high
`timescale 1ns/1ps
interface rsqc_tmr_if;
  import rsqc_pkg::*;
  logic             start;
  logic [TMR_W-1:0] load;
  logic             expired;
  modport user  (output start, output load, input expired);
  modport timer (input start, input load, output expired);
endinterface

// ===== rsqc_timer.sv
// Purpose: down-counting delay timer on the always-running reference
// Assumes: load value of at least one cycle
// Notes:   expired is high while the count stands at zero
`timescale 1ns/1ps
module rsqc_timer (
  // clock and reset
  input wire logic     aclk,
  input wire logic     aresetn,
  // control
  rsqc_tmr_if.timer    tmr
);
  import rsqc_pkg::*;
  logic [TMR_W-1:0] cnt;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= '0;
    end else if (tmr.start) begin
      cnt <= tmr.load;
    end else if (cnt != '0) begin
      cnt <= cnt - TMR_W'(1);
    end
  end

  assign tmr.expired = (cnt == '0);
endmodule

// ===== rsqc_seq.sv
// Purpose: reset cause flags, clock choice and release timing
// Assumes: reset sources and oscillator ticks synchronous to aclk
// Notes:   aclk is the free-running reference, valid before the system clock
`timescale 1ns/1ps
// Notes on behaviour
// - any active reset source holds the internal system reset
// - power-on clears every flag except the power-on flag, and sets the power-on and brown-out flags
// - power-on flag in bit 0 set by power-on, never cleared by hardware otherwise
// - software writes any flag freely; writing never causes a reset
// - watchdog stays enabled while its fuse reads one
// - trap and bad-opcode flags set by events, cleared by power-on or brown-out
// - watchdog flag set on time-out, cleared by power-save, power-on, brown-out
// - switching on: power-on/brown-out use fuse source, others keep current source
// - switching off: the fuse source is always used; software writes to ADDR_OSC still change it here
// - system reset released only after the delays of its reset type have run
// - power-on waits power-on, start-up, reset time; brown-out skips power-on
// - start-up 20 us with regulator, 64 ms timer without; wake adds the 20 us only with regulator on
// - other resets apply only the 20 us internal reset time
// - crystal sources count 1024 oscillator periods, plus lock for pll modes
// - pll sources withhold the clock for the 20 us lock time
// - oscillator counting and lock run alongside the release delays
// - processor runs only once reset is released and the clock is valid
// - monitor starts at release; missing clock switches to fast rc and traps
// - crystal or pll sources add a monitor start delay after a power-on or brown-out release
module rsqc_seq #(
  parameter logic [rsqc_pkg::TMR_W-1:0] PWRUP_CYCLES = rsqc_pkg::PWRUP_CYC
) (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite write address and data
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // axi4-lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // reset sources
  input  wire logic              por_event,
  input  wire logic              bor_event,
  input  wire logic              master_clear_pin,
  input  wire logic              dog_timeout_evt,
  input  wire logic              soft_reset_evt,
  input  wire logic              bad_opcode_evt,
  input  wire logic              trap_conflict_evt,
  // power-save instruction and wake
  input  wire logic              power_save_instr,
  input  wire logic              power_save_idle,
  input  wire logic              wake_evt,
  // configuration fuses and straps
  input  wire logic              fuse_dog_enable,
  input  wire logic [2:0]        fuse_osc_select,
  input  wire logic              clock_switch_enable,
  input  wire logic              regulator_enable,
  input  wire logic              failsafe_enable,
  // clock system
  input  wire logic              osc_tick,
  input  wire logic              osc_valid,
  // outputs to core and clock system
  output logic                   system_reset_n,
  output logic                   clock_released,
  output logic                   cpu_run,
  output logic                   dog_enabled,
  output logic [2:0]             osc_select,
  output logic                   monitor_active,
  output logic                   switch_to_frc,
  output logic                   failsafe_trap
);
  import rsqc_pkg::*;

  // ------------------------------------------------------------
  // sources and sequence
  // ------------------------------------------------------------
  rsqc_tmr_if t_seq ();
  rsqc_tmr_if t_lock ();
  rsqc_tmr_if t_mon ();

  rsqc_timer u_seq  (.aclk(aclk), .aresetn(aresetn), .tmr(t_seq));
  rsqc_timer u_lock (.aclk(aclk), .aresetn(aresetn), .tmr(t_lock));
  rsqc_timer u_mon  (.aclk(aclk), .aresetn(aresetn), .tmr(t_mon));

  rsqc_state_t state;
  rsqc_state_t next_state;
  logic        any_src;
  logic        long_rst;
  logic        por_pend;
  logic        rel_pulse;
  logic        hold_exit;
  logic [2:0]  chosen_osc;
  logic        chosen_xtal;
  logic        chosen_pll;
  logic        cur_xtal;
  logic        cur_pll;
  logic [TMR_W-1:0] start_cyc;
  logic [15:0] flags;

  assign any_src = por_event | bor_event | master_clear_pin | dog_timeout_evt |
                   soft_reset_evt | bad_opcode_evt | trap_conflict_evt;
  // regulator off swaps in the long power-up timer
  assign start_cyc = regulator_enable ? STARTUP_CYC : PWRUP_CYCLES;
  assign hold_exit = (state == ST_HOLD) && !any_src;
  // fuse choice on long resets or with switching off, else keep current
  assign chosen_osc = (!clock_switch_enable || long_rst) ?
                      fuse_osc_select : osc_select;
  assign chosen_xtal = (chosen_osc == OSC_XT) || (chosen_osc == OSC_XTPLL) ||
                       (chosen_osc == OSC_SOSC);
  assign chosen_pll  = (chosen_osc == OSC_FRCPLL) || (chosen_osc == OSC_XTPLL) ||
                       (chosen_osc == OSC_ECPLL);
  assign cur_xtal = (osc_select == OSC_XT) || (osc_select == OSC_XTPLL) ||
                    (osc_select == OSC_SOSC);
  assign cur_pll  = (osc_select == OSC_FRCPLL) || (osc_select == OSC_XTPLL) ||
                    (osc_select == OSC_ECPLL);

  always_comb begin
    next_state  = state;
    t_seq.start = 1'b0;
    t_seq.load  = RST_CYC;
    rel_pulse   = 1'b0;
    case (state)
      ST_HOLD: begin
        if (!any_src) begin
          t_seq.start = 1'b1;
          if (por_pend) begin
            next_state = ST_POR;
            t_seq.load = POR_CYC;
          end else if (long_rst) begin
            next_state = ST_START;
            t_seq.load = start_cyc;
          end else begin
            next_state = ST_RST;
            t_seq.load = RST_CYC;
          end
        end
      end
      ST_POR: begin
        if (t_seq.expired) begin
          next_state  = ST_START;
          t_seq.start = 1'b1;
          t_seq.load  = start_cyc;
        end
      end
      ST_START: begin
        if (t_seq.expired) begin
          next_state  = ST_RST;
          t_seq.start = 1'b1;
          t_seq.load  = RST_CYC;
        end
      end
      ST_RST: begin
        if (t_seq.expired) begin
          next_state = ST_RUN;
          rel_pulse  = 1'b1;
        end
      end
      ST_RUN: begin
        if (wake_evt && regulator_enable) begin
          next_state  = ST_WAKE;
          t_seq.start = 1'b1;
          t_seq.load  = STARTUP_CYC;
        end
      end
      ST_WAKE: begin
        if (t_seq.expired) begin
          next_state = ST_RUN;
        end
      end
      default: begin
        next_state = ST_HOLD;
      end
    endcase
    if (any_src) begin
      next_state  = ST_HOLD;
      t_seq.start = 1'b0;
      rel_pulse   = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state    <= ST_HOLD;
      long_rst <= 1'b1;
      por_pend <= 1'b1;
    end else begin
      state <= next_state;
      if (any_src) begin
        long_rst <= long_rst | por_event | bor_event;
        por_pend <= por_pend | por_event;
      end else begin
        if (hold_exit) begin
          por_pend <= 1'b0;
        end
        // kept until release: the monitor delay decision reads it there
        if (rel_pulse) begin
          long_rst <= 1'b0;
        end
      end
    end
  end

  // counts run on aclk, which never stops, so delays hold before any clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      system_reset_n <= 1'b0;
      cpu_run        <= 1'b0;
      dog_enabled    <= 1'b1;
    end else begin
      system_reset_n <= (next_state == ST_RUN) || (next_state == ST_WAKE);
      cpu_run        <= (next_state == ST_RUN) && clock_released;
      dog_enabled    <= fuse_dog_enable | flags[BIT_SDOG];
    end
  end

  // ------------------------------------------------------------
  // oscillator start-up and pll lock
  // ------------------------------------------------------------
  logic [9:0] ost_cnt;
  logic       ost_run;
  logic       lock_run;
  logic       ost_done;

  // start-up counting begins with the reset delays, not after them
  assign ost_done     = ost_run && osc_tick && (ost_cnt == OST_LAST);
  assign t_lock.start = (hold_exit && long_rst && chosen_pll && !chosen_xtal) ||
                        (ost_done && cur_pll);
  assign t_lock.load  = LOCK_CYC;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ost_cnt        <= 10'h000;
      ost_run        <= 1'b0;
      lock_run       <= 1'b0;
      clock_released <= 1'b0;
    end else if (any_src && (por_event || bor_event)) begin
      ost_cnt        <= 10'h000;
      ost_run        <= 1'b0;
      lock_run       <= 1'b0;
      clock_released <= 1'b0;
    end else if (hold_exit && long_rst) begin
      ost_cnt        <= 10'h000;
      ost_run        <= chosen_xtal;
      lock_run       <= chosen_pll && !chosen_xtal;
      clock_released <= !chosen_xtal && !chosen_pll;
    end else if (switch_to_frc) begin
      ost_run        <= 1'b0;
      lock_run       <= 1'b0;
      clock_released <= 1'b1;
    end else begin
      if (ost_run && osc_tick) begin
        ost_cnt <= ost_cnt + 10'h001;
      end
      if (ost_done) begin
        ost_run        <= 1'b0;
        lock_run       <= cur_pll;
        clock_released <= !cur_pll;
      end
      if (lock_run && !t_lock.start && t_lock.expired) begin
        lock_run       <= 1'b0;
        clock_released <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // fail-safe clock monitor
  // ------------------------------------------------------------
  logic mon_wait;
  logic mon_delay;

  // only long resets on crystal or pll sources wait before monitoring
  assign mon_delay   = long_rst && (cur_xtal || cur_pll);
  assign t_mon.start = rel_pulse && failsafe_enable && mon_delay;
  assign t_mon.load  = MON_CYC;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mon_wait       <= 1'b0;
      monitor_active <= 1'b0;
      switch_to_frc  <= 1'b0;
      failsafe_trap  <= 1'b0;
    end else begin
      failsafe_trap <= 1'b0;
      if (any_src) begin
        mon_wait       <= 1'b0;
        monitor_active <= 1'b0;
        switch_to_frc  <= 1'b0;
      end else if (rel_pulse && failsafe_enable) begin
        mon_wait       <= mon_delay;
        monitor_active <= !mon_delay;
      end else if (mon_wait && t_mon.expired) begin
        mon_wait       <= 1'b0;
        monitor_active <= 1'b1;
      end else if (monitor_active && !osc_valid && !switch_to_frc) begin
        switch_to_frc <= 1'b1;
        failsafe_trap <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // axi4-lite slave
  // ------------------------------------------------------------
  logic       aw_held;
  logic       w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic       wr_fire;
  logic [15:0] wr_mask;

  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign wr_mask = {{8{w_strb[1]}}, {8{w_strb[0]}}};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr == ADDR_FLAGS || aw_addr == ADDR_OSC ||
                         aw_addr == ADDR_STATUS) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        case (s_axi_araddr)
          ADDR_FLAGS:  s_axi_rdata <= {16'h0000, flags};
          ADDR_OSC:    s_axi_rdata <= {17'h00000, osc_select, 12'h000};
          ADDR_STATUS: s_axi_rdata <= {24'h000000, 2'h0, switch_to_frc, monitor_active,
                                       cpu_run, clock_released, system_reset_n, dog_enabled};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // reset cause flags and current oscillator
  // ------------------------------------------------------------
  logic [15:0] set_bits;
  logic [15:0] clr_bits;
  logic [15:0] sw_val;

  always_comb begin
    set_bits = 16'h0000;
    clr_bits = 16'h0000;
    set_bits[BIT_POR]   = por_event;
    set_bits[BIT_BOR]   = por_event | bor_event;
    set_bits[BIT_PIN]   = master_clear_pin;
    set_bits[BIT_SOFT]  = soft_reset_evt;
    set_bits[BIT_DOGTO] = dog_timeout_evt;
    set_bits[BIT_BADOP] = bad_opcode_evt;
    set_bits[BIT_TRAP]  = trap_conflict_evt;
    set_bits[BIT_SLEEP] = power_save_instr & !power_save_idle;
    set_bits[BIT_IDLE]  = power_save_instr & power_save_idle;
    if (por_event) begin
      clr_bits = FLAGS_MASK & ~(16'h0001 << BIT_POR);
    end else if (bor_event) begin
      clr_bits[BIT_TRAP]  = 1'b1;
      clr_bits[BIT_BADOP] = 1'b1;
      clr_bits[BIT_SOFT]  = 1'b1;
      clr_bits[BIT_DOGTO] = 1'b1;
      clr_bits[BIT_SLEEP] = 1'b1;
      clr_bits[BIT_IDLE]  = 1'b1;
    end
    clr_bits[BIT_DOGTO] = clr_bits[BIT_DOGTO] | power_save_instr;
    // software write only stores a value; it never feeds any_src
    sw_val = (wr_fire && aw_addr == ADDR_FLAGS) ?
             ((flags & ~wr_mask) | (w_data[15:0] & wr_mask)) : flags;
  end

  // events win over both software writes and hardware clears
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags <= FLAGS_RESET;
    end else begin
      flags <= ((sw_val & ~clr_bits) | set_bits) & FLAGS_MASK;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_select <= OSC_FRC;
    end else if (switch_to_frc == 1'b0 && monitor_active && !osc_valid) begin
      osc_select <= OSC_FRC;
    end else if (hold_exit) begin
      osc_select <= chosen_osc;
    end else if (wr_fire && aw_addr == ADDR_OSC && w_strb[1]) begin
      osc_select <= w_data[OSC_LSB +: 3];
    end
  end
endmodule

// ===== rsqc_asserts.sv
// Purpose: port assertions for the reset sequencer
// Assumes: one clock, synchronous active-low reset
// Notes:   release length allows slack for state hand-over
`timescale 1ns/1ps
module rsqc_asserts (
  // clock, reset and sources
  input wire logic       aclk, aresetn, por_event, bor_event, master_clear_pin,
  input wire logic       dog_timeout_evt, soft_reset_evt, bad_opcode_evt, trap_conflict_evt,
  // configuration and outputs
  input wire logic       fuse_dog_enable, clock_switch_enable, system_reset_n,
  input wire logic       clock_released, cpu_run, dog_enabled, monitor_active,
  input wire logic       switch_to_frc, s_axi_bvalid, s_axi_bready,
  input wire logic [2:0] osc_select,
  input wire logic [1:0] s_axi_bresp
);
  logic       src;
  logic       shrt;
  logic [9:0] low_n;
  assign src = por_event | bor_event | master_clear_pin | dog_timeout_evt
    | soft_reset_evt | bad_opcode_evt | trap_conflict_evt;
  assign shrt = (master_clear_pin | dog_timeout_evt | trap_conflict_evt) & ~por_event
    & ~bor_event & clock_switch_enable & system_reset_n;
  // saturates so a long power-up wait cannot wrap back under the bound
  always_ff @(posedge aclk) begin
    if (!aresetn || src || system_reset_n) low_n <= 10'h0;
    else if (low_n != 10'h3ff) low_n <= low_n + 10'h1;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_SRC_HOLD: assert property (src |=> !system_reset_n)
    else $error("reset not held");
  AST_REL_LEN: assert property ($rose(system_reset_n) |-> low_n >= 10'd197)
    else $error("early release");
  AST_RUN_RST: assert property (!system_reset_n |-> !cpu_run)
    else $error("run in reset");
  AST_RUN_CLK: assert property (!clock_released |=> !cpu_run)
    else $error("run without clock");
  AST_DOG_FUSE: assert property (fuse_dog_enable |=> dog_enabled)
    else $error("dog off");
  AST_MON_REL: assert property (monitor_active |-> system_reset_n)
    else $error("monitor in reset");
  AST_FRC_SEL: assert property ($rose(switch_to_frc) |-> ##[0:2] osc_select == 3'h0)
    else $error("no fast rc");
  AST_OSC_KEEP: assert property (shrt |=> $stable(osc_select))
    else $error("osc changed");
  AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("bvalid stuck");
  cover property (switch_to_frc);
  cover property ($rose(cpu_run));
  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule

// ===== rsqc_osc_model.sv
// Purpose: oscillator model feeding the sequencer
// Assumes: one period every two reference cycles
// Notes:   dropping alive fakes a dead crystal; ticks then stop
`timescale 1ns/1ps
module rsqc_osc_model (
  input  wire logic aclk,
  input  wire logic alive,
  output logic      osc_tick,
  output logic      osc_valid
);
  always @(posedge aclk) osc_tick <= alive && (osc_tick !== 1'b1);
  assign osc_valid = alive;
endmodule

// ===== tb.sv
// Purpose: directed bench for the reset sequencer
// Assumes: regulator on, crystal fuse source, short power-up timer
// Notes:   crystal start-up outlasts the power-on release on purpose
`timescale 1ns/1ps
module tb;
  import rsqc_pkg::*;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, power_save_idle, wake_evt, fuse_dog_enable, failsafe_enable;
  logic        clock_switch_enable, regulator_enable, alive, osc_tick, osc_valid;
  logic        system_reset_n, clock_released, cpu_run, dog_enabled;
  logic        monitor_active, switch_to_frc, failsafe_trap;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, ev;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [2:0]  fuse_osc_select, osc_select;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          num_errors = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          n;
  rsqc_seq #(.PWRUP_CYCLES(20'd50)) rsqc_seq_i (.*, .por_event(ev[0]), .bor_event(ev[1]),
    .master_clear_pin(ev[2]), .dog_timeout_evt(ev[3]), .soft_reset_evt(ev[4]),
    .bad_opcode_evt(ev[5]), .trap_conflict_evt(ev[6]), .power_save_instr(ev[7]));
  rsqc_osc_model rsqc_osc_model_i (.aclk, .alive, .osc_tick, .osc_valid);
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  task automatic summarize;
    if (num_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      summarize();
    end
  end
  task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic wr32(logic [7:0] a, logic [31:0] d, logic [1:0] er);
    logic da, dw;
    {da, dw} = 2'b00;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid} <= 2'b11;
    while (!(da && dw)) begin
      @(negedge aclk);
      da = da | s_axi_awready;
      dw = dw | s_axi_wready;
      @(posedge aclk);
      if (da) s_axi_awvalid <= 1'b0;
      if (dw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b1;
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    chk("bresp", s_axi_bresp, er);
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd32(logic [7:0] a, logic [31:0] e, logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(negedge aclk); while (s_axi_arready !== 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    chk("rdata", s_axi_rdata, e);
    chk("rresp", s_axi_rresp, er);
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask
  task automatic rel;
    n = 0;
    do begin @(negedge aclk); n++; end while (system_reset_n !== 1'b1);
  endtask
  task automatic hit(int k);
    @(posedge aclk);
    ev <= 8'h1 << k;
    @(posedge aclk);
    ev <= 8'h0;
  endtask
  task automatic s_boot;
    rel();
    chk("por_len", n >= 498 && n <= 506, 1'b1);
    chk("clk_early", clock_released, 1'b0);
    chk("osc_por", osc_select, OSC_XT);
    repeat (990) @(negedge aclk);
    chk("mon_early", monitor_active, 1'b0);
    repeat (20) @(negedge aclk);
    chk("mon_on", monitor_active, 1'b1);
    n = 0;
    do begin @(negedge aclk); n++; end while (cpu_run !== 1'b1);
    chk("ost_len", n > 480 && n < 600, 1'b1);
  endtask
  task automatic s_flags;
    rd32(ADDR_FLAGS, 32'h3, RESP_OKAY);
    rd32(8'h0c, 32'h0, RESP_SLVERR);
    wr32(8'h0c, 32'hffff, RESP_SLVERR);
    wr32(ADDR_FLAGS, 32'hc0, RESP_OKAY);
    rd32(ADDR_FLAGS, 32'hc0, RESP_OKAY);
    chk("no_reset", system_reset_n, 1'b1);
    hit(0);
    rel();
    rd32(ADDR_FLAGS, 32'h3, RESP_OKAY);
  endtask
  task automatic s_short;
    for (int k = 2; k < 7; k++) begin
      hit(k);
      rel();
      chk("short_len", n >= 196 && n <= 206, 1'b1);
      chk("osc_keep", osc_select, OSC_XT);
    end
    rd32(ADDR_FLAGS, 32'hc0d3, RESP_OKAY);
    rd32(ADDR_OSC, 32'h2000, RESP_OKAY);
    hit(1);
    rel();
    chk("bor_len", n >= 396 && n <= 406, 1'b1);
    rd32(ADDR_FLAGS, 32'h83, RESP_OKAY);
  endtask
  task automatic s_dog;
    wr32(ADDR_FLAGS, 32'h20, RESP_OKAY);
    @(negedge aclk);
    chk("dog_soft", dog_enabled, 1'b1);
    wr32(ADDR_FLAGS, 32'h0, RESP_OKAY);
    @(negedge aclk);
    chk("dog_off", dog_enabled, 1'b0);
    @(posedge aclk);
    fuse_dog_enable <= 1'b1;
    repeat (2) @(negedge aclk);
    chk("dog_fuse", dog_enabled, 1'b1);
    @(posedge aclk);
    {fuse_dog_enable, clock_switch_enable} <= 2'b00;
    fuse_osc_select <= OSC_EC;
    hit(3);
    rel();
    chk("osc_fuse", osc_select, OSC_EC);
    rd32(ADDR_FLAGS, 32'h10, RESP_OKAY);
    hit(7);
    rd32(ADDR_FLAGS, 32'h8, RESP_OKAY);
  endtask
  task automatic s_fail;
    do @(negedge aclk); while (monitor_active !== 1'b1);
    @(posedge aclk);
    alive <= 1'b0;
    do @(negedge aclk); while (switch_to_frc !== 1'b1);
    chk("frc_osc", osc_select, OSC_FRC);
    chk("frc_trap", failsafe_trap, 1'b1);
  endtask
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {power_save_idle, wake_evt, fuse_dog_enable, ev, s_axi_awaddr, s_axi_araddr} = '0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h3;
    fuse_osc_select = OSC_XT;
    {clock_switch_enable, regulator_enable, failsafe_enable, alive} = 4'hf;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    s_boot();
    s_flags();
    s_short();
    s_dog();
    s_fail();
    summarize();
  end
endmodule
bind rsqc_seq rsqc_asserts rsqc_asserts_i (.*);
